// ---- rssq_defines.svh ----
// constants for the reset, supply and clock sequencer
// assumes a single 50 MHz clock; included by the package and the top module
// Functional notes
// - hold static reset while supply is low
// - rising threshold above falling threshold, hysteresis
// - drive reset pin low during supply-low reset
// - supply-low flag set by hardware, cleared writing zero
// - supply threshold level fixed by option setting
// - all sources drive pin low through delay
// - start address fetched from top two bytes
// - phases: source delay, 4096 clocks, vector fetch
// - vector fetch lasts exactly two clocks
// - external reset pulse detected without clock
// - recognised external pulse stretched to minimum width
// - power-on and voltage-drop sequences are distinguished
// - watchdog underflow drives pin low minimum width
// - clock source chosen from seven option settings
// - crystal oscillators keep running during reset
// - watchdog flag set, cleared by zero or supply-low
// - supply-low flag survives pin and watchdog resets
`ifndef RSSQ_DEFINES_SVH
`define RSSQ_DEFINES_SVH

`define RSSQ_CLK_MHZ        50
`define RSSQ_OUT_WIDTH_NS   30000
`define RSSQ_OUT_CYCLES     ((`RSSQ_OUT_WIDTH_NS * `RSSQ_CLK_MHZ) / 1000)
`define RSSQ_STAB_CYCLES    4096
`define RSSQ_FETCH_CYCLES   2
`define RSSQ_VECTOR_LO      16'hFFFE
`define RSSQ_VECTOR_HI      16'hFFFF
`define RSSQ_CNT_W          16

`endif

// ---- rssq_pkg.sv ----
// types of the reset, supply and clock sequencer
// assumes rssq_defines.svh is on the include path
`include "rssq_defines.svh"
package rssq_pkg;

    typedef enum logic [4:0] {
        RSSQ_RUN   = 5'h01,
        RSSQ_DELAY = 5'h02,
        RSSQ_STAB  = 5'h04,
        RSSQ_FETCH = 5'h08,
        RSSQ_HOLD  = 5'h10
    } rssq_phase_t;

    typedef enum logic [1:0] {
        RSSQ_LVL_LOW  = 2'h0,
        RSSQ_LVL_MID  = 2'h1,
        RSSQ_LVL_HIGH = 2'h2
    } rssq_level_t;

    typedef enum logic [2:0] {
        RSSQ_CLK_EXT  = 3'h0,
        RSSQ_CLK_XT0  = 3'h1,
        RSSQ_CLK_XT1  = 3'h2,
        RSSQ_CLK_XT2  = 3'h3,
        RSSQ_CLK_XT3  = 3'h4,
        RSSQ_CLK_ERC  = 3'h5,
        RSSQ_CLK_IRC  = 3'h6
    } rssq_clksrc_t;

    typedef struct packed {
        logic        supplyLowResetFlag;
        logic        watchdogResetFlag;
    } rssq_cause_t;

    typedef struct packed {
        logic        cpuInReset;
        logic        vectorFetch;
        logic [15:0] fetchAddr;
    } rssq_cpu_t;

endpackage : rssq_pkg

// ---- rssq_reset_supply_clock_sequencer.sv ----
// reset, supply and clock sequencer of a small 8-bit controller
// assumes clock is the main oscillator and keeps running during reset;
// supply comparators and the pin pad are outside, reached via plain ports
`timescale 1ns/1ps
`default_nettype none
`include "rssq_defines.svh"
module rssq_reset_supply_clock_sequencer #(
    parameter int STAB_CYCLES = `RSSQ_STAB_CYCLES,
    parameter int OUT_CYCLES  = `RSSQ_OUT_CYCLES
) (
    input  wire logic                  clock,
    input  wire logic                  rst,
    input  wire logic                  resetPinIn,
    input  wire logic                  extResetLatched,
    output logic                       extResetAck,
    input  wire logic                  aboveRisingThreshold,
    input  wire logic                  aboveFallingThreshold,
    input  wire logic                  watchdogUnderflow,
    input  wire logic                  flagWrite,
    input  wire rssq_pkg::rssq_cause_t flagWriteData,
    input  wire rssq_pkg::rssq_level_t optSupplyLevel,
    input  wire rssq_pkg::rssq_clksrc_t optClockSource,
    output logic                       resetPinOut,
    output logic                       resetPinOe,
    output rssq_pkg::rssq_cause_t      causeFlags,
    output rssq_pkg::rssq_cpu_t        cpuCtl,
    output rssq_pkg::rssq_level_t      thresholdSelect,
    output rssq_pkg::rssq_clksrc_t     clockSourceSelect,
    output logic                       oscEnable,
    output logic                       powerOnSeq,
    output logic                       voltageDropSeq
);

    // =========================================================
    // pin synchronisers
    // =========================================================
    // the latch outside catches a pulse with no clock; only its output is sampled here
    logic [2:0] extSync;
    logic [2:0] pinSync;
    logic [2:0] oeHist;
    logic       extSeen;
    logic       supplyOk;
    logic       supplyLow;
    logic       extReq;

    always_ff @(posedge clock) begin
        if (rst) begin
            extSync <= 3'h0;
        end else begin
            extSync <= {extSync[1:0], extResetLatched};
        end
    end

    // own drive history, aligned with the pin samples: the pin still reads low
    // for two clocks after release, which must not count as an outside pull
    always_ff @(posedge clock) begin
        if (rst) begin
            pinSync <= 3'h7;
            oeHist  <= 3'h0;
        end else begin
            pinSync <= {pinSync[1:0], resetPinIn};
            oeHist  <= {oeHist[1:0], resetPinOe};
        end
    end

    assign extSeen = extSync[1] & extSync[2];
    assign extReq  = extSeen | (~pinSync[1] & ~pinSync[2] & oeHist[1] & oeHist[2]);

    // =========================================================
    // supply-low hysteresis
    // =========================================================
    // threshold comparators are async pins as well
    logic [2:0] riseSync;
    logic [2:0] fallSync;

    always_ff @(posedge clock) begin
        if (rst) begin
            riseSync <= 3'h0;
            fallSync <= 3'h0;
        end else begin
            riseSync <= {riseSync[1:0], aboveRisingThreshold};
            fallSync <= {fallSync[1:0], aboveFallingThreshold};
        end
    end

    // ok only once above the rising level, lost only below the falling level
    always_ff @(posedge clock) begin
        if (rst) begin
            supplyOk <= 1'b0;
        end else if (riseSync[1] & riseSync[2]) begin
            supplyOk <= 1'b1;
        end else if (~fallSync[1] & ~fallSync[2]) begin
            supplyOk <= 1'b0;
        end
    end

    assign supplyLow = ~supplyOk;

    // power-on versus voltage-drop distinction
    logic everRan;
    logic wasOk;

    always_ff @(posedge clock) begin
        if (rst) begin
            everRan <= 1'b0;
        end else if (supplyOk) begin
            everRan <= 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            wasOk <= 1'b0;
        end else begin
            wasOk <= supplyOk;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            powerOnSeq     <= 1'b0;
            voltageDropSeq <= 1'b0;
        end else if (wasOk & supplyLow) begin
            voltageDropSeq <= 1'b1;
            powerOnSeq     <= 1'b0;
        end else if (~everRan & supplyLow) begin
            powerOnSeq     <= 1'b1;
            voltageDropSeq <= 1'b0;
        end else if (cpuCtl.cpuInReset == 1'b0) begin
            powerOnSeq     <= 1'b0;
            voltageDropSeq <= 1'b0;
        end
    end

    // =========================================================
    // phase sequencer
    // =========================================================
    rssq_pkg::rssq_phase_t phase;
    logic [`RSSQ_CNT_W-1:0] cnt;
    logic                   cntZero;
    logic                   anyReq;

    assign anyReq  = extReq | watchdogUnderflow | supplyLow;
    assign cntZero = (cnt == '0);

    // phase order: a pin or watchdog request restarts from the source delay; supply low goes to the hold phase
    always_ff @(posedge clock) begin
        if (rst) begin
            phase <= rssq_pkg::RSSQ_HOLD;
        end else if (supplyLow) begin
            phase <= rssq_pkg::RSSQ_HOLD;
        end else if (anyReq) begin
            phase <= rssq_pkg::RSSQ_DELAY;
        end else begin
            unique case (phase)
                rssq_pkg::RSSQ_RUN: begin
                    phase <= rssq_pkg::RSSQ_RUN;
                end
                rssq_pkg::RSSQ_HOLD: begin
                    // supply back: still owe the pin its minimum width
                    phase <= rssq_pkg::RSSQ_DELAY;
                end
                rssq_pkg::RSSQ_DELAY: begin
                    if (cntZero) begin
                        phase <= rssq_pkg::RSSQ_STAB;
                    end
                end
                rssq_pkg::RSSQ_STAB: begin
                    if (cntZero) begin
                        phase <= rssq_pkg::RSSQ_FETCH;
                    end
                end
                rssq_pkg::RSSQ_FETCH: begin
                    if (cntZero) begin
                        phase <= rssq_pkg::RSSQ_RUN;
                    end
                end
            endcase
        end
    end

    // one down-counter serves all timed phases; reloaded on every entry
    always_ff @(posedge clock) begin
        if (rst) begin
            cnt <= '0;
        end else if (supplyLow) begin
            cnt <= '0;
        end else if (anyReq) begin
            cnt <= `RSSQ_CNT_W'(OUT_CYCLES - 1);
        end else begin
            unique case (phase)
                rssq_pkg::RSSQ_RUN: begin
                    cnt <= cnt;
                end
                rssq_pkg::RSSQ_HOLD: begin
                    cnt <= `RSSQ_CNT_W'(OUT_CYCLES - 1);
                end
                rssq_pkg::RSSQ_DELAY: begin
                    cnt <= cntZero ? `RSSQ_CNT_W'(STAB_CYCLES - 1) : cnt - 1'b1;
                end
                rssq_pkg::RSSQ_STAB: begin
                    cnt <= cntZero ? `RSSQ_CNT_W'(`RSSQ_FETCH_CYCLES - 1) : cnt - 1'b1;
                end
                rssq_pkg::RSSQ_FETCH: begin
                    cnt <= cntZero ? cnt : cnt - 1'b1;
                end
            endcase
        end
    end

    // =========================================================
    // reset pin and cpu outputs
    // =========================================================
    // open drain: oe low means driving the pin low
    always_ff @(posedge clock) begin
        if (rst) begin
            resetPinOut <= 1'b0;
        end else begin
            resetPinOut <= 1'b0;
        end
    end

    // release only once the source delay is over
    always_ff @(posedge clock) begin
        if (rst) begin
            resetPinOe <= 1'b0;
        end else begin
            resetPinOe <= ~(anyReq | phase == rssq_pkg::RSSQ_HOLD
                            | phase == rssq_pkg::RSSQ_DELAY);
        end
    end

    // ack mirrors the synced latch so the latch outside clears once seen
    always_ff @(posedge clock) begin
        if (rst) begin
            extResetAck <= 1'b0;
        end else begin
            extResetAck <= extSeen;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            cpuCtl <= '{cpuInReset: 1'b1, vectorFetch: 1'b0, fetchAddr: `RSSQ_VECTOR_LO};
        end else begin
            cpuCtl.cpuInReset  <= anyReq | (phase != rssq_pkg::RSSQ_RUN);
            cpuCtl.vectorFetch <= ~anyReq & (phase == rssq_pkg::RSSQ_FETCH);
            // low byte in the first fetch cycle, high byte in the second
            cpuCtl.fetchAddr   <= (phase == rssq_pkg::RSSQ_FETCH && cnt == '0)
                                  ? `RSSQ_VECTOR_HI : `RSSQ_VECTOR_LO;
        end
    end

    // =========================================================
    // reset cause flags
    // =========================================================
    always_ff @(posedge clock) begin
        if (rst) begin
            causeFlags <= '0;
        end else begin
            if (supplyLow) begin
                causeFlags.supplyLowResetFlag <= 1'b1;
            end else if (flagWrite & ~flagWriteData.supplyLowResetFlag) begin
                causeFlags.supplyLowResetFlag <= 1'b0;
            end
            if (supplyLow) begin
                causeFlags.watchdogResetFlag <= 1'b0;
            end else if (watchdogUnderflow) begin
                causeFlags.watchdogResetFlag <= 1'b1;
            end else if (flagWrite & ~flagWriteData.watchdogResetFlag) begin
                causeFlags.watchdogResetFlag <= 1'b0;
            end
        end
    end

    // =========================================================
    // option settings and oscillator
    // =========================================================
    // options are latched only in reset so run-time pin changes cannot move them
    always_ff @(posedge clock) begin
        if (rst) begin
            thresholdSelect   <= rssq_pkg::RSSQ_LVL_LOW;
            clockSourceSelect <= rssq_pkg::RSSQ_CLK_IRC;
        end else if (phase == rssq_pkg::RSSQ_HOLD) begin
            thresholdSelect   <= optSupplyLevel;
            clockSourceSelect <= optClockSource;
        end
    end

    // oscillator never stopped, not even in reset, so no start-up time is lost
    always_ff @(posedge clock) begin
        if (rst) begin
            oscEnable <= 1'b1;
        end else begin
            oscEnable <= 1'b1;
        end
    end

endmodule : rssq_reset_supply_clock_sequencer
`default_nettype wire

// ---- rssq_sva.sv ----
// checker of the sequencer top ports
// assumes one clock domain with synchronous rst
`timescale 1ns/1ps
`default_nettype none
module rssq_sva #(
    parameter int STAB_CYCLES = 8,
    parameter int OUT_CYCLES  = 4
) (
    input wire logic                  clock,
    input wire logic                  rst,
    input wire logic                  extResetAck,
    input wire logic                  aboveFallingThreshold,
    input wire logic                  watchdogUnderflow,
    input wire logic                  resetPinOut,
    input wire logic                  resetPinOe,
    input wire rssq_pkg::rssq_cause_t causeFlags,
    input wire rssq_pkg::rssq_cpu_t   cpuCtl,
    input wire logic                  oscEnable
);
    // helper counters keep the long timed checks out of delay operators
    int lowCnt;
    int sinceRel;
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    always_ff @(posedge clock) begin
        if (rst || resetPinOe) begin
            lowCnt <= 0;
        end else begin
            lowCnt <= lowCnt + 1;
        end
    end
    always_ff @(posedge clock) begin
        if (rst || !resetPinOe || !cpuCtl.cpuInReset) begin
            sinceRel <= 0;
        end else if (!cpuCtl.vectorFetch) begin
            sinceRel <= sinceRel + 1;
        end
    end
    pin_level_a: assert property (resetPinOut == 1'b0 && oscEnable) else $error("pin level or osc wrong");
    wdg_pin_a: assert property (watchdogUnderflow |=> !resetPinOe && cpuCtl.cpuInReset) else $error("wdg no pin");
    wdg_flag_a: assert property (watchdogUnderflow && aboveFallingThreshold |=> causeFlags.watchdogResetFlag)
        else $error("wdg flag not set");
    supply_hold_a: assert property (!aboveFallingThreshold [*6] |-> !resetPinOe && cpuCtl.cpuInReset
        && causeFlags.supplyLowResetFlag && !causeFlags.watchdogResetFlag) else $error("supply low hold");
    fetch_seq_a: assert property ($rose(cpuCtl.vectorFetch) |-> cpuCtl.fetchAddr == 16'hFFFE ##1
        (cpuCtl.vectorFetch && cpuCtl.fetchAddr == 16'hFFFF) ##1 (!cpuCtl.vectorFetch && !cpuCtl.cpuInReset))
        else $error("fetch sequence wrong");
    stab_len_a: assert property ($rose(cpuCtl.vectorFetch) |-> sinceRel == STAB_CYCLES)
        else $error("stabilise count wrong");
    pin_width_a: assert property ($rose(resetPinOe) |-> lowCnt >= OUT_CYCLES)
        else $error("pin pulse short");
    ext_pin_a: assert property ($rose(extResetAck) |-> ##[0:2] !resetPinOe) else $error("ext no pin");
    cpu_held_a: assert property (!resetPinOe |-> cpuCtl.cpuInReset) else $error("cpu free early");
    fetch_c: cover property ($rose(cpuCtl.vectorFetch));
    wdg_c: cover property (watchdogUnderflow);
    ext_c: cover property ($rose(extResetAck));
endmodule : rssq_sva
bind rssq_reset_supply_clock_sequencer rssq_sva #(.STAB_CYCLES(STAB_CYCLES), .OUT_CYCLES(OUT_CYCLES)) chk (
    .clock(clock), .rst(rst), .extResetAck(extResetAck), .aboveFallingThreshold(aboveFallingThreshold),
    .watchdogUnderflow(watchdogUnderflow), .resetPinOut(resetPinOut), .resetPinOe(resetPinOe),
    .causeFlags(causeFlags), .cpuCtl(cpuCtl), .oscEnable(oscEnable));
`default_nettype wire

// ---- rssq_board_model.sv ----
// board side of the reset pin: pull-up, outside pulse, catch latch
// assumes extPull pulses come from the bench
`timescale 1ns/1ps
`default_nettype none
module rssq_board_model (
    input  wire logic resetPinOut,
    input  wire logic resetPinOe,
    input  wire logic extPull,
    input  wire logic extResetAck,
    output logic      resetPinIn,
    output logic      extResetLatched
);
    // weak pull-up wins only when nobody pulls low
    assign resetPinIn = ((!resetPinOe && !resetPinOut) || extPull) ? 1'b0 : 1'b1;
    initial extResetLatched = 1'b0;
    // no clock here, so sub-period pulses are caught
    always @(posedge extPull or posedge extResetAck) begin
        if (extResetAck)
            extResetLatched <= 1'b0;
        else
            extResetLatched <= 1'b1;
    end
endmodule : rssq_board_model
`default_nettype wire

// ---- tb.sv ----
// bench: power cycles, watchdog, short pin pulse, restart
// assumes board model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
module tb;
    localparam int STAB = 8;
    localparam int OUTC = 4;
    logic clock = 0, rst = 1, extPull = 0, supRise = 0, supFall = 0, wdg = 0, flagWr = 0;
    logic pinIn, latched, ack, pinOut, pinOe, oscEn, pOn, vDrop;
    rssq_pkg::rssq_cause_t flagData = '0, cause;
    rssq_pkg::rssq_cpu_t cpu;
    rssq_pkg::rssq_level_t lvl = rssq_pkg::RSSQ_LVL_LOW, thrSel;
    rssq_pkg::rssq_clksrc_t src = rssq_pkg::RSSQ_CLK_EXT, srcSel;
    int errors = 0, nChecks = 0, cycles = 0;
    rssq_reset_supply_clock_sequencer #(.STAB_CYCLES(STAB), .OUT_CYCLES(OUTC)) dut (
        .clock(clock), .rst(rst), .resetPinIn(pinIn), .extResetLatched(latched), .extResetAck(ack),
        .aboveRisingThreshold(supRise), .aboveFallingThreshold(supFall), .watchdogUnderflow(wdg),
        .flagWrite(flagWr), .flagWriteData(flagData), .optSupplyLevel(lvl), .optClockSource(src),
        .resetPinOut(pinOut), .resetPinOe(pinOe), .causeFlags(cause), .cpuCtl(cpu), .thresholdSelect(thrSel),
        .clockSourceSelect(srcSel), .oscEnable(oscEn), .powerOnSeq(pOn), .voltageDropSeq(vDrop));
    rssq_board_model board (.resetPinOut(pinOut), .resetPinOe(pinOe), .extPull(extPull),
        .extResetAck(ack), .resetPinIn(pinIn), .extResetLatched(latched));
    initial forever #10 clock = ~clock;
    // ==========================================
    // compare and timing helpers
    task automatic check_val(input string name, input logic [2:0] exp, input logic [2:0] got);
        nChecks++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask : check_val
    task automatic check_cnt(input string name, input int exp, input int got);
        nChecks++;
        if (got != exp) begin
            errors++;
            $display("ERROR %s expected %0d seen %0d", name, exp, got);
        end
    endtask : check_cnt
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : cyc
    // counts edges until the cpu runs; negative exp skips the compare
    task automatic run_out(input int exp);
        int n;
        n = 0;
        while (cpu.cpuInReset !== 1'b0 && n < 300) begin
            cyc(1);
            n++;
        end
        check_val("cpu running", 3'h0, {2'h0, cpu.cpuInReset});
        if (exp >= 0) check_cnt("sequence length", exp, n);
    endtask : run_out
    task automatic pulse_wdg;
        wdg = 1;
        cyc(1);
        wdg = 0;
    endtask : pulse_wdg
    // ==========================================
    // scenarios
    task automatic power_cycle(input logic drop, input int i);
        lvl = rssq_pkg::rssq_level_t'(i % 3);
        src = rssq_pkg::rssq_clksrc_t'(i);
        if (drop) begin
            supRise = 0;
            cyc(8);
            check_val("between thresholds", 3'h0, {2'h0, cpu.cpuInReset});
            supFall = 0;
        end
        cyc(6);
        check_val("pin", 3'h0, {2'h0, pinIn});
        check_val("cpu held", 3'h1, {2'h0, cpu.cpuInReset});
        check_val("flags", 3'h2, {1'b0, cause});
        check_val("sequence kind", drop ? 3'h1 : 3'h2, {1'b0, pOn, vDrop});
        check_val("level", {1'b0, lvl}, {1'b0, thrSel});
        check_val("clock source", src, srcSel);
        supFall = 1;
        cyc(10);
        check_val("rising hold", 3'h1, {2'h0, cpu.cpuInReset});
        supRise = 1;
        run_out(-1);
    endtask : power_cycle
    task automatic watchdog_test;
        pulse_wdg();
        run_out(1 + OUTC + STAB + 2);
        check_val("flags after wdg", 3'h3, {1'b0, cause});
    endtask : watchdog_test
    task automatic clear_restart;
        flagWr = 1;
        cyc(1);
        flagWr = 0;
        check_val("flags cleared", 3'h0, {1'b0, cause});
        pulse_wdg();
        cyc(2);
        pulse_wdg();
        run_out(1 + OUTC + STAB + 2);
        check_val("flags restart", 3'h1, {1'b0, cause});
    endtask : clear_restart
    task automatic ext_pulse;
        #5 extPull = 1;
        #5 extPull = 0;
        cyc(6);
        check_val("stretched pin", 3'h0, {2'h0, pinIn});
        run_out(-1);
    endtask : ext_pulse
    task automatic stop_test;
        $display("checks %0d errors %0d", nChecks, errors);
        if (errors == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test
    // ceiling well above the few hundred cycles the run needs
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            errors++;
            stop_test();
        end
    end
    initial begin
        cyc(5);
        rst = 0;
        power_cycle(1'b0, 0);
        watchdog_test();
        for (int i = 0; i < 7; i++) power_cycle(1'b1, i);
        clear_restart();
        ext_pulse();
        stop_test();
    end
endmodule : tb
`default_nettype wire
